// ### ccb_ctrl_regs.sv
// Charger control four (bits 1:0) and control five register logic
`timescale 1ns/1ns
`include "ccb_params.svh"

module ccb_ctrl_regs #(
    parameter int ADC_W = 12,
    parameter int SETTLE_CYC = `CCB_HALT_SETTLE_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register port from the serial interface engine
    input wire ccb_pkg::ccb_addr_t reg_addr,
    input wire ccb_pkg::ccb_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output ccb_pkg::ccb_data_t reg_rdata,
    // Reset sources, same clock
    input wire logic register_reset,
    input wire logic watchdog_expiry,
    // Analog comparator, asynchronous
    input wire logic battery_above_minimum_system_voltage,
    // Ship switch fields held in another register
    input wire logic ship_switch_force_off_raw,
    input wire logic [1:0] ship_switch_control_raw,
    output logic ship_switch_force_off,
    output logic [1:0] ship_switch_control,
    // Converter and ADC for detection
    output logic converter_halt,
    output logic adc_start,
    input wire logic adc_done,
    input wire logic [ADC_W-1:0] adc_code,
    output logic threshold_wr,
    output logic [ADC_W-1:0] threshold_data,
    // Field outputs to the charger core
    output logic input_voltage_limit_detect_request,
    output logic input_overcurrent_protect_enable,
    output logic ship_switch_fitted,
    output logic battery_discharge_overcurrent_enable,
    output logic discharge_sense_enable,
    output logic discharge_limit_disabled,
    output logic [2:0] discharge_limit_amps,
    output logic internal_input_current_limit_enable,
    output logic external_current_limit_enable
);
    import ccb_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [2:0] limit_amps(input logic [1:0] code);
        unique case (code)
            `CCB_LIMIT_3A: limit_amps = 3'h3;
            `CCB_LIMIT_4A: limit_amps = 3'h4;
            `CCB_LIMIT_5A: limit_amps = 3'h5;
            `CCB_LIMIT_OFF: limit_amps = 3'h0;
        endcase
    endfunction

    // ****************************************
    // State
    // ****************************************
    logic vbat_meta_ff, vbat_ok_ff;
    logic det_req_ff, nxt_det_req;
    logic ocp_en_ff, nxt_ocp_en;
    logic fitted_ff, nxt_fitted;
    logic sense_ff, nxt_sense;
    logic [1:0] limit_ff, nxt_limit;
    logic iin_ff, nxt_iin;
    logic ext_ff, nxt_ext;
    logic batoc_ff, nxt_batoc;
    logic sfo_ff, nxt_sfo;
    logic [1:0] sctl_ff, nxt_sctl;
    logic lim_off_ff, nxt_lim_off;
    logic [2:0] lim_amps_ff, nxt_lim_amps;
    ccb_data_t rdata_ff, nxt_rdata;
    logic det_busy, det_done;
    logic wr4, wr5;

    assign wr4 = reg_wr && (reg_addr == `CCB_OFS_CTRL_FOUR);
    assign wr5 = reg_wr && (reg_addr == `CCB_OFS_CTRL_FIVE);

    // ****************************************
    // Detection sequencer
    // ****************************************
    ccb_vdet_seq #(
        .ADC_W(ADC_W),
        .SETTLE_CYC(SETTLE_CYC)
    ) u_seq (
        .mclk(mclk),
        .nrst(nrst),
        // Request still reads 1 in the done cycle; gate it so no second run starts
        .start(det_req_ff && !det_busy && !det_done),
        .abort(register_reset),
        .busy(det_busy),
        .done(det_done),
        .converter_halt(converter_halt),
        .adc_start(adc_start),
        .adc_done(adc_done),
        .adc_code(adc_code),
        .threshold_wr(threshold_wr),
        .threshold_data(threshold_data)
    );

    // ****************************************
    // Next register values
    // ****************************************
    always_comb begin
        nxt_det_req = det_req_ff;
        nxt_ocp_en = ocp_en_ff;
        nxt_fitted = fitted_ff;
        nxt_sense = sense_ff;
        nxt_limit = limit_ff;
        nxt_iin = iin_ff;
        nxt_ext = ext_ff;
        nxt_batoc = batoc_ff;
        if (register_reset) begin
            nxt_det_req = `CCB_C4_DET_REQ_RST;
            nxt_ocp_en = `CCB_C4_OCP_EN_RST;
            nxt_fitted = `CCB_C5_FITTED_RST;
            nxt_sense = `CCB_C5_SENSE_RST;
            nxt_limit = `CCB_C5_LIMIT_RST;
            nxt_iin = `CCB_C5_IIN_RST;
            nxt_ext = `CCB_C5_EXT_RST;
            nxt_batoc = `CCB_C5_BATOC_RST;
        end else begin
            // Watchdog leaves request, protect enable, fitted and pin enable alone
            if (watchdog_expiry) begin
                nxt_sense = `CCB_C5_SENSE_RST;
                nxt_limit = `CCB_C5_LIMIT_RST;
                nxt_iin = `CCB_C5_IIN_RST;
                nxt_batoc = `CCB_C5_BATOC_RST;
            end
            // Clear first so a same-cycle accepted write keeps the request
            if (det_done) begin
                nxt_det_req = 1'h0;
            end
            if (wr4) begin
                // Writing 0 cannot cancel a running detection
                if (reg_wdata[`CCB_C4_DET_REQ_BIT] && vbat_ok_ff) begin
                    nxt_det_req = 1'h1;
                end
                nxt_ocp_en = reg_wdata[`CCB_C4_OCP_EN_BIT];
            end
            // A write in the watchdog cycle wins, software saw the newer state
            if (wr5) begin
                nxt_fitted = reg_wdata[`CCB_C5_FITTED_BIT];
                nxt_sense = reg_wdata[`CCB_C5_SENSE_BIT];
                nxt_limit = reg_wdata[`CCB_C5_LIMIT_HI:`CCB_C5_LIMIT_LO];
                nxt_iin = reg_wdata[`CCB_C5_IIN_BIT];
                nxt_ext = reg_wdata[`CCB_C5_EXT_BIT];
                nxt_batoc = reg_wdata[`CCB_C5_BATOC_BIT];
            end
        end
        if (!nxt_fitted) begin
            nxt_batoc = 1'h0;
        end
    end

    // ****************************************
    // Derived outputs and read data
    // ****************************************
    always_comb begin
        nxt_sfo = ship_switch_force_off_raw & fitted_ff;
        nxt_sctl = fitted_ff ? ship_switch_control_raw : 2'h0;
        nxt_lim_off = (limit_ff == `CCB_LIMIT_OFF);
        nxt_lim_amps = limit_amps(limit_ff);
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            unique case (reg_addr)
                `CCB_OFS_CTRL_FOUR: nxt_rdata = {6'h00, det_req_ff, ocp_en_ff};
                `CCB_OFS_CTRL_FIVE: nxt_rdata = {fitted_ff, 1'h0, sense_ff, limit_ff,
                    iin_ff, ext_ff, batoc_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            vbat_meta_ff <= 1'h0;
            vbat_ok_ff <= 1'h0;
            det_req_ff <= `CCB_C4_DET_REQ_RST;
            ocp_en_ff <= `CCB_C4_OCP_EN_RST;
            fitted_ff <= `CCB_C5_FITTED_RST;
            sense_ff <= `CCB_C5_SENSE_RST;
            limit_ff <= `CCB_C5_LIMIT_RST;
            iin_ff <= `CCB_C5_IIN_RST;
            ext_ff <= `CCB_C5_EXT_RST;
            batoc_ff <= `CCB_C5_BATOC_RST;
            sfo_ff <= 1'h0;
            sctl_ff <= 2'h0;
            lim_off_ff <= 1'h0;
            lim_amps_ff <= 3'h5;
            rdata_ff <= 8'h00;
        end else begin
            vbat_meta_ff <= battery_above_minimum_system_voltage;
            vbat_ok_ff <= vbat_meta_ff;
            det_req_ff <= nxt_det_req;
            ocp_en_ff <= nxt_ocp_en;
            fitted_ff <= nxt_fitted;
            sense_ff <= nxt_sense;
            limit_ff <= nxt_limit;
            iin_ff <= nxt_iin;
            ext_ff <= nxt_ext;
            batoc_ff <= nxt_batoc;
            sfo_ff <= nxt_sfo;
            sctl_ff <= nxt_sctl;
            lim_off_ff <= nxt_lim_off;
            lim_amps_ff <= nxt_lim_amps;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign input_voltage_limit_detect_request = det_req_ff;
    assign input_overcurrent_protect_enable = ocp_en_ff;
    assign ship_switch_fitted = fitted_ff;
    assign battery_discharge_overcurrent_enable = batoc_ff;
    assign discharge_sense_enable = sense_ff;
    assign discharge_limit_disabled = lim_off_ff;
    assign discharge_limit_amps = lim_amps_ff;
    assign internal_input_current_limit_enable = iin_ff;
    assign external_current_limit_enable = ext_ff;
    assign ship_switch_force_off = sfo_ff;
    assign ship_switch_control = sctl_ff;

endmodule

// ### ccb_params.svh
// Offsets, field positions, reset values and timing counts for the charger control bits
`ifndef CCB_PARAMS_SVH
`define CCB_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define CCB_OFS_CTRL_FOUR 8'h13
`define CCB_OFS_CTRL_FIVE 8'h14

// ****************************************
// Control four field positions and resets
// ****************************************
`define CCB_C4_DET_REQ_BIT 1
`define CCB_C4_OCP_EN_BIT 0
`define CCB_C4_DET_REQ_RST 1'h0
`define CCB_C4_OCP_EN_RST 1'h1

// ****************************************
// Control five field positions and resets
// ****************************************
`define CCB_C5_FITTED_BIT 7
`define CCB_C5_RSVD_BIT 6
`define CCB_C5_SENSE_BIT 5
`define CCB_C5_LIMIT_HI 4
`define CCB_C5_LIMIT_LO 3
`define CCB_C5_IIN_BIT 2
`define CCB_C5_EXT_BIT 1
`define CCB_C5_BATOC_BIT 0
`define CCB_C5_RESET 8'h16
`define CCB_C5_FITTED_RST 1'h0
`define CCB_C5_SENSE_RST 1'h0
`define CCB_C5_LIMIT_RST 2'h2
`define CCB_C5_IIN_RST 1'h1
`define CCB_C5_EXT_RST 1'h1
`define CCB_C5_BATOC_RST 1'h0

// ****************************************
// Discharge limit codes and currents in amps
// ****************************************
`define CCB_LIMIT_3A 2'h0
`define CCB_LIMIT_4A 2'h1
`define CCB_LIMIT_5A 2'h2
`define CCB_LIMIT_OFF 2'h3

// ****************************************
// Timing
// ****************************************
`define CCB_CLK_PERIOD_NS 40
`define CCB_HALT_SETTLE_NS 2000
`define CCB_HALT_SETTLE_CYC ((`CCB_HALT_SETTLE_NS + `CCB_CLK_PERIOD_NS - 1) / `CCB_CLK_PERIOD_NS)

`endif

// ### ccb_pkg.sv
// Types shared by the charger control bits design
package ccb_pkg;

    typedef logic [7:0] ccb_addr_t;
    typedef logic [7:0] ccb_data_t;

    // Gray coded along idle, halt, sample, update
    typedef enum logic [1:0] {
        CCB_DET_IDLE   = 2'h0,
        CCB_DET_HALT   = 2'h1,
        CCB_DET_SAMPLE = 2'h3,
        CCB_DET_UPDATE = 2'h2
    } ccb_det_state_t;

endpackage

// ### ccb_vdet_seq.sv
// Input voltage limit detection sequencer: halt, sample, update
`timescale 1ns/1ns
`include "ccb_params.svh"

module ccb_vdet_seq #(
    parameter int ADC_W = 12,
    parameter int SETTLE_CYC = `CCB_HALT_SETTLE_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Control
    input wire logic start,
    input wire logic abort,
    output logic busy,
    output logic done,
    // Converter and converter ADC
    output logic converter_halt,
    output logic adc_start,
    input wire logic adc_done,
    input wire logic [ADC_W-1:0] adc_code,
    // Threshold register update
    output logic threshold_wr,
    output logic [ADC_W-1:0] threshold_data
);
    import ccb_pkg::*;

    localparam int CNT_W = $clog2(SETTLE_CYC + 1);
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

    ccb_det_state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic halt_ff, nxt_halt;
    logic adc_start_ff, nxt_adc_start;
    logic thr_wr_ff, nxt_thr_wr;
    logic [ADC_W-1:0] thr_data_ff, nxt_thr_data;
    logic done_ff, nxt_done;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_halt = halt_ff;
        nxt_adc_start = 1'h0;
        nxt_thr_wr = 1'h0;
        nxt_thr_data = thr_data_ff;
        nxt_done = 1'h0;
        if (abort) begin
            nxt_state = CCB_DET_IDLE;
            nxt_halt = 1'h0;
            nxt_cnt = '0;
        end else begin
            unique case (state_ff)
                CCB_DET_IDLE: begin
                    if (start) begin
                        nxt_state = CCB_DET_HALT;
                        nxt_halt = 1'h1;
                        nxt_cnt = '0;
                    end
                end
                CCB_DET_HALT: begin
                    // Let input current decay before sampling the bus
                    if (cnt_ff == SETTLE_LAST) begin
                        nxt_state = CCB_DET_SAMPLE;
                        nxt_adc_start = 1'h1;
                    end else begin
                        nxt_cnt = cnt_ff + CNT_W'(1);
                    end
                end
                CCB_DET_SAMPLE: begin
                    if (adc_done) begin
                        nxt_state = CCB_DET_UPDATE;
                        nxt_thr_data = adc_code;
                        nxt_thr_wr = 1'h1;
                    end
                end
                CCB_DET_UPDATE: begin
                    nxt_state = CCB_DET_IDLE;
                    nxt_halt = 1'h0;
                    nxt_done = 1'h1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= CCB_DET_IDLE;
            cnt_ff <= '0;
            halt_ff <= 1'h0;
            adc_start_ff <= 1'h0;
            thr_wr_ff <= 1'h0;
            thr_data_ff <= '0;
            done_ff <= 1'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            halt_ff <= nxt_halt;
            adc_start_ff <= nxt_adc_start;
            thr_wr_ff <= nxt_thr_wr;
            thr_data_ff <= nxt_thr_data;
            done_ff <= nxt_done;
        end
    end

    assign busy = (state_ff != CCB_DET_IDLE);
    assign done = done_ff;
    assign converter_halt = halt_ff;
    assign adc_start = adc_start_ff;
    assign threshold_wr = thr_wr_ff;
    assign threshold_data = thr_data_ff;

endmodule

// ### ccb_ctrl_regs_properties.sv
// Concurrent checks on the charger control bits register logic ports
`timescale 1ns/1ns

module ccb_ctrl_regs_properties #(
    parameter int ADC_W = 12
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register port and reset sources
    input wire ccb_pkg::ccb_addr_t reg_addr,
    input wire ccb_pkg::ccb_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire ccb_pkg::ccb_data_t reg_rdata,
    input wire logic register_reset,
    input wire logic watchdog_expiry,
    // Detection
    input wire logic converter_halt,
    input wire logic adc_done,
    input wire logic [ADC_W-1:0] adc_code,
    input wire logic threshold_wr,
    input wire logic [ADC_W-1:0] threshold_data,
    // Fields
    input wire logic ship_switch_force_off,
    input wire logic [1:0] ship_switch_control,
    input wire logic input_voltage_limit_detect_request,
    input wire logic input_overcurrent_protect_enable,
    input wire logic ship_switch_fitted,
    input wire logic battery_discharge_overcurrent_enable,
    input wire logic discharge_sense_enable,
    input wire logic discharge_limit_disabled,
    input wire logic [2:0] discharge_limit_amps,
    input wire logic internal_input_current_limit_enable,
    input wire logic external_current_limit_enable
);
    import ccb_pkg::*;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // ****************************************
    // Properties
    // ****************************************
    chk_req_from_write: assert property ($rose(input_voltage_limit_detect_request) |->
        $past(reg_wr && reg_addr == 8'h13 && reg_wdata[1]))
        else $error("detect request rose without a write");
    chk_req_halts: assert property ($rose(input_voltage_limit_detect_request) |=>
        converter_halt) else $error("detect request did not halt converter");
    chk_thr_data: assert property (threshold_wr |-> $past(adc_done) &&
        threshold_data == $past(adc_code)) else $error("threshold not from adc result");
    chk_req_clears: assert property (threshold_wr |=> !converter_halt ##1
        (!input_voltage_limit_detect_request || $past(reg_wr)))
        else $error("detect request did not clear");
    chk_ocp_holds: assert property (!register_reset && !(reg_wr && reg_addr == 8'h13) |=>
        $stable(input_overcurrent_protect_enable)) else $error("ocp enable changed");
    chk_ship_locked: assert property (($past(ship_switch_fitted) ||
        (!ship_switch_force_off && ship_switch_control == 2'h0)) &&
        (ship_switch_fitted || !battery_discharge_overcurrent_enable))
        else $error("ship fields not held zero");
    chk_wd_keeps: assert property (watchdog_expiry && !reg_wr && !register_reset |=>
        $stable(external_current_limit_enable) && $stable(ship_switch_fitted))
        else $error("watchdog changed a kept field");
    chk_wd_resets: assert property (watchdog_expiry && !reg_wr && !register_reset |=>
        (!discharge_sense_enable && internal_input_current_limit_enable) ##1
        (discharge_limit_amps == 3'h5)) else $error("watchdog fields not restored");
    chk_limit_off: assert property (discharge_limit_disabled |->
        discharge_limit_amps == 3'h0) else $error("disabled limit shows current");
    chk_rsvd_zero: assert property (reg_rd && reg_addr == 8'h14 |=>
        !reg_rdata[6]) else $error("reserved bit read one");
    chk_reg_reset: assert property (register_reset |=> !input_voltage_limit_detect_request
        && input_overcurrent_protect_enable && !ship_switch_fitted && !converter_halt
        && external_current_limit_enable && !discharge_sense_enable)
        else $error("register reset left a field");
endmodule

bind ccb_ctrl_regs ccb_ctrl_regs_properties #(.ADC_W(ADC_W)) ccb_ctrl_regs_properties_i (
    .mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .register_reset,
    .watchdog_expiry, .converter_halt, .adc_done, .adc_code, .threshold_wr, .threshold_data,
    .ship_switch_force_off, .ship_switch_control, .input_voltage_limit_detect_request,
    .input_overcurrent_protect_enable, .ship_switch_fitted,
    .battery_discharge_overcurrent_enable, .discharge_sense_enable, .discharge_limit_disabled,
    .discharge_limit_amps, .internal_input_current_limit_enable,
    .external_current_limit_enable);

// ### testbench.sv
// Self-checking bench for the charger control bits register logic
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end

module testbench;
    import ccb_pkg::*;

    logic mclk = 1'b0;
    logic nrst = 1'b0;
    ccb_addr_t reg_addr = 8'h00;
    ccb_data_t reg_wdata = 8'h00;
    ccb_data_t reg_rdata;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rr = 1'b0;
    logic wd = 1'b0;
    logic batt = 1'b0;
    logic fo_raw = 1'b1;
    logic [1:0] ctl_raw = 2'h3;
    logic fo, halt, adc_start, thr_wr, req, ocp, fitted, batoc, sense, lim_off, iin, ext;
    logic [1:0] ctl;
    logic [2:0] amps;
    logic adc_done = 1'b0;
    logic [11:0] adc_code = 12'h000;
    logic [11:0] thr_data;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [2:0] amps_tab [4] = '{3'h3, 3'h4, 3'h5, 3'h0};

    always #20 mclk = ~mclk;

    ccb_ctrl_regs #(.ADC_W(12), .SETTLE_CYC(2)) ccb_ctrl_regs_i (
        .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .register_reset(rr),
        .watchdog_expiry(wd), .battery_above_minimum_system_voltage(batt),
        .ship_switch_force_off_raw(fo_raw), .ship_switch_control_raw(ctl_raw),
        .ship_switch_force_off(fo), .ship_switch_control(ctl), .converter_halt(halt),
        .adc_start(adc_start), .adc_done(adc_done), .adc_code(adc_code),
        .threshold_wr(thr_wr), .threshold_data(thr_data),
        .input_voltage_limit_detect_request(req), .input_overcurrent_protect_enable(ocp),
        .ship_switch_fitted(fitted), .battery_discharge_overcurrent_enable(batoc),
        .discharge_sense_enable(sense), .discharge_limit_disabled(lim_off),
        .discharge_limit_amps(amps), .internal_input_current_limit_enable(iin),
        .external_current_limit_enable(ext));

    // ****************************************
    // Access tasks
    // ****************************************
    task automatic wr(input ccb_addr_t a, input ccb_data_t d);
        @(posedge mclk);
        #2;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #2;
        reg_wr = 1'b0;
    endtask

    task automatic chkrd(input ccb_addr_t a, input ccb_data_t exp);
        @(posedge mclk);
        #2;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk);
        #2;
        reg_rd = 1'b0;
        #40;
        `CHK(reg_rdata, exp)
    endtask

    // One-cycle pulse on register reset or on watchdog expiry
    task automatic pulse(input bit dog);
        @(posedge mclk);
        #2;
        if (dog) wd = 1'b1; else rr = 1'b1;
        @(posedge mclk);
        #2;
        wd = 1'b0;
        rr = 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge mclk);
        #2;
        nrst = 1'b1;
        chkrd(8'h13, 8'h01);
        chkrd(8'h14, 8'h16);
        chkrd(8'h20, 8'h00);
        `CHK(fo, 1'b0)
        wr(8'h14, 8'hFF);
        chkrd(8'h14, 8'hBF);
        `CHK({fo, ctl}, 3'h7)
        for (int c = 0; c < 4; c++) begin
            wr(8'h14, 8'h80 | 8'(c << 3));
            #40;
            `CHK(amps, amps_tab[c])
            `CHK(lim_off, c == 3)
        end
        // Watchdog keeps fitted, ext and the ocp enable
        wr(8'h13, 8'h00);
        wr(8'h14, 8'hA1);
        pulse(1'b1);
        chkrd(8'h14, 8'h94);
        chkrd(8'h13, 8'h00);
        `CHK({fitted, sense, iin, ext, batoc, ocp}, 6'h28)
        pulse(1'b0);
        chkrd(8'h14, 8'h16);
        chkrd(8'h13, 8'h01);
        `CHK({fo, ctl}, 3'h0)
        wr(8'h14, 8'h01);
        chkrd(8'h14, 8'h00);
        // Comparator low refuses the request
        wr(8'h13, 8'h03);
        chkrd(8'h13, 8'h01);
        batt = 1'b1;
        #200;
        wr(8'h13, 8'h03);
        `CHK(req, 1'b1)
        for (int i = 0; i < 10 && halt !== 1'b1; i++) #40;
        `CHK(halt, 1'b1)
        for (int i = 0; i < 20 && adc_start !== 1'b1; i++) #40;
        `CHK(adc_start, 1'b1)
        #40;
        adc_code = 12'hABC;
        adc_done = 1'b1;
        #40;
        adc_done = 1'b0;
        for (int i = 0; i < 5 && thr_wr !== 1'b1; i++) #40;
        `CHK({thr_wr, thr_data}, 13'h1ABC)
        for (int i = 0; i < 10 && req !== 1'b0; i++) #40;
        `CHK({req, halt}, 2'h0)
        chkrd(8'h13, 8'h01);
        // Register reset aborts a running detection
        wr(8'h13, 8'h02);
        for (int i = 0; i < 10 && halt !== 1'b1; i++) #40;
        pulse(1'b0);
        `CHK({req, halt, thr_wr}, 3'h0)
        tally_and_finish();
    end
endmodule
